// *** core/sbc_standby.sv ***
`default_nettype none

module sbc_standby (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  resetn,
	// Instruction stream and release events
	input  wire logic                  halt_exec,
	input  wire logic                  stop_exec,
	input  wire logic                  irq_pending,
	// CPU clock source currently selected
	input  wire logic                  cpu_on_internal,
	input  wire logic                  cpu_on_subsys,
	// Clock generator control bits and their write-one pulses
	input  wire logic                  main_osc_halt_bit,
	input  wire logic                  main_osc_halt_wr1,
	input  wire logic                  cpu_clock_main_off_wr1,
	input  wire logic                  internal_osc_halt_bit,
	input  wire logic                  opt_int_osc_stoppable,
	// Oscillator outputs arriving as pins
	input  wire logic                  hs_osc_clk_in,
	input  wire logic                  int_osc_clk_in,
	// Register port
	input  wire sbc_pkg::sbc_sfr_req_t sfr_req,
	output var  logic [7:0]            sfr_rdata,
	output var  logic                  sfr_rvalid,
	// Clock and hold controls
	output var  sbc_pkg::sbc_clk_ctl_t clk_ctl,
	output var  logic                  halt_active,
	output var  logic                  stop_active
);

	// Map a select code to the status bit of its threshold
	function automatic int unsigned sel_to_bit(input logic [2:0] sel);
		case (sel)
			sbc_pkg::SEL_2P11: sel_to_bit = sbc_pkg::BIT_2P11;
			sbc_pkg::SEL_2P13: sel_to_bit = sbc_pkg::BIT_2P13;
			sbc_pkg::SEL_2P14: sel_to_bit = sbc_pkg::BIT_2P14;
			sbc_pkg::SEL_2P15: sel_to_bit = sbc_pkg::BIT_2P15;
			// Prohibited codes fall back to the longest wait
			default:           sel_to_bit = sbc_pkg::BIT_2P16;
		endcase
	endfunction : sel_to_bit

	sbc_pkg::sbc_state_t              state_q;
	sbc_pkg::sbc_state_t              state_d;
	logic [sbc_pkg::CNT_W-1:0]        cnt_q;
	logic [sbc_pkg::CNT_W-1:0]        cnt_d;
	logic [sbc_pkg::NUM_STEPS-1:0]    status_q;
	logic [sbc_pkg::NUM_STEPS-1:0]    status_d;
	logic [sbc_pkg::NUM_STEPS-1:0]    reached;
	logic [2:0]                       select_q;
	logic [2:0]                       select_d;
	logic                             limit_q;
	logic                             limit_d;
	logic [4:0]                       int_cnt_q;
	logic [4:0]                       int_cnt_d;
	logic                             hs_s1_q;
	logic                             hs_s2_q;
	logic                             hs_s3_q;
	logic                             int_s1_q;
	logic                             int_s2_q;
	logic                             int_s3_q;
	logic                             hs_edge;
	logic                             int_edge;
	logic                             settle_clear;
	logic                             sel_reached;
	logic                             cnt_run;
	logic                             stop_ok;
	logic                             sel_status;
	logic                             sel_select;
	logic [7:0]                       status_byte;
	logic [7:0]                       select_byte;
	logic [7:0]                       read_byte;
	logic [7:0]                       rdata_d;
	logic                             hs_en_d;
	logic                             int_en_d;
	logic                             int_osc_off;

	// Oscillator pins: two flops, then a third for edge detection
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			hs_s1_q  <= 1'b0;
			hs_s2_q  <= 1'b0;
			hs_s3_q  <= 1'b0;
			int_s1_q <= 1'b0;
			int_s2_q <= 1'b0;
			int_s3_q <= 1'b0;
		end else begin
			hs_s1_q  <= hs_osc_clk_in;
			hs_s2_q  <= hs_s1_q;
			hs_s3_q  <= hs_s2_q;
			int_s1_q <= int_osc_clk_in;
			int_s2_q <= int_s1_q;
			int_s3_q <= int_s2_q;
		end
	end

	// One pulse per oscillator period; edges only exist once it oscillates
	assign hs_edge  = hs_s2_q & ~hs_s3_q;
	assign int_edge = int_s2_q & ~int_s3_q;

	// Threshold comparison per status bit
	genvar gi;
	generate
		for (gi = 0; gi < sbc_pkg::NUM_STEPS; gi++) begin : g_step
			assign reached[gi] = cnt_q >= sbc_pkg::CNT_W'(1 << sbc_pkg::STEP_EXP[gi]);
		end
	endgenerate

	// STOP from the subsystem clock is not a legal entry and is ignored
	assign stop_ok      = stop_exec & ~cpu_on_subsys;
	assign settle_clear = (state_q == sbc_pkg::ST_RUN && stop_ok)
		| main_osc_halt_wr1 | cpu_clock_main_off_wr1;
	assign sel_reached  = reached[sel_to_bit(select_q)];

	// After a STOP release the counter freezes at the selected wait
	assign cnt_run = hs_edge & clk_ctl.hs_osc_enable
		& ~(limit_q & sel_reached) & (cnt_q != sbc_pkg::CNT_MAX);

	// Settling counter and sticky thermometer status
	always_comb begin
		cnt_d    = cnt_q;
		status_d = status_q | reached;
		limit_d  = limit_q;
		if (settle_clear) begin
			cnt_d    = '0;
			status_d = '0;
			limit_d  = 1'b0;
		end else if (cnt_run) begin
			cnt_d = cnt_q + sbc_pkg::CNT_W'(1);
		end
		if (state_q == sbc_pkg::ST_STOP && irq_pending) begin
			limit_d = 1'b1;
		end
	end

	// Internal oscillator period counter for the post-STOP hold
	always_comb begin
		int_cnt_d = int_cnt_q;
		if (state_q != sbc_pkg::ST_WINT) begin
			int_cnt_d = '0;
		end else if (int_edge) begin
			int_cnt_d = int_cnt_q + 5'h01;
		end
	end

	// Standby sequencer
	always_comb begin
		case (state_q)
			sbc_pkg::ST_RUN: begin
				if (stop_ok) begin
					state_d = sbc_pkg::ST_STOP;
				end else if (halt_exec) begin
					state_d = sbc_pkg::ST_HALT;
				end else begin
					state_d = sbc_pkg::ST_RUN;
				end
			end
			sbc_pkg::ST_HALT: begin
				// Release with no wait: oscillators never stopped
				state_d = irq_pending ? sbc_pkg::ST_RUN : sbc_pkg::ST_HALT;
			end
			sbc_pkg::ST_STOP: begin
				if (!irq_pending) begin
					state_d = sbc_pkg::ST_STOP;
				end else if (cpu_on_internal) begin
					state_d = sbc_pkg::ST_WINT;
				end else begin
					state_d = sbc_pkg::ST_WHS;
				end
			end
			sbc_pkg::ST_WHS: begin
				state_d = sel_reached ? sbc_pkg::ST_RUN : sbc_pkg::ST_WHS;
			end
			sbc_pkg::ST_WINT: begin
				state_d = (int_cnt_q >= sbc_pkg::INT_WAIT_PERIODS) ? sbc_pkg::ST_RUN
					: sbc_pkg::ST_WINT;
			end
			default: begin
				state_d = sbc_pkg::ST_RUN;
			end
		endcase
	end

	// Oscillator enables; STOP only touches the high-speed one
	assign int_osc_off = opt_int_osc_stoppable & internal_osc_halt_bit;
	assign hs_en_d     = ~main_osc_halt_bit & (state_d != sbc_pkg::ST_STOP);
	assign int_en_d    = ~int_osc_off;

	// Register decode and read data
	assign sel_status  = sfr_req.addr == sbc_pkg::SETTLE_STATUS_ADDR;
	assign sel_select  = sfr_req.addr == sbc_pkg::SETTLE_SELECT_ADDR;
	assign status_byte = {3'h0, status_q};
	assign select_byte = {5'h00, select_q};
	assign read_byte   = sel_status ? status_byte : sel_select ? select_byte : 8'h00;
	assign rdata_d     = sfr_req.bit_acc ? {7'h00, read_byte[sfr_req.bitsel]}
		: read_byte;

	// Select register takes byte writes only; status ignores writes
	assign select_d = (sfr_req.wr && !sfr_req.bit_acc && sel_select)
		? sfr_req.wdata[2:0] : select_q;

	// Counter, status and select state
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cnt_q     <= '0;
			status_q  <= sbc_pkg::SETTLE_STATUS_RST[sbc_pkg::NUM_STEPS-1:0];
			limit_q   <= 1'b0;
			select_q  <= sbc_pkg::SETTLE_SELECT_RST;
			int_cnt_q <= '0;
		end else begin
			cnt_q     <= cnt_d;
			status_q  <= status_d;
			limit_q   <= limit_d;
			select_q  <= select_d;
			int_cnt_q <= int_cnt_d;
		end
	end

	// Sequencer state
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_q <= sbc_pkg::ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Registered controls; hold freezes latches and memory writes in standby
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			clk_ctl.cpu_clk_en     <= 1'b1;
			clk_ctl.hs_osc_enable  <= 1'b0;
			clk_ctl.int_osc_enable <= 1'b1;
			clk_ctl.standby_hold   <= 1'b0;
			halt_active            <= 1'b0;
			stop_active            <= 1'b0;
		end else begin
			clk_ctl.cpu_clk_en     <= state_d == sbc_pkg::ST_RUN;
			clk_ctl.hs_osc_enable  <= hs_en_d;
			clk_ctl.int_osc_enable <= int_en_d;
			clk_ctl.standby_hold   <= state_d != sbc_pkg::ST_RUN;
			halt_active            <= state_d == sbc_pkg::ST_HALT;
			stop_active            <= state_d == sbc_pkg::ST_STOP;
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sfr_rdata  <= 8'h00;
			sfr_rvalid <= 1'b0;
		end else begin
			sfr_rdata  <= sfr_req.rd ? rdata_d : 8'h00;
			sfr_rvalid <= sfr_req.rd;
		end
	end

endmodule : sbc_standby

`default_nettype wire

// *** core/sbc_pkg.sv ***
// Function
// - HALT instruction stops the CPU clock
// - HALT keeps running oscillators oscillating
// - HALT released immediately by interrupt, no wait
// - STOP instruction halts high-speed oscillator, whole system
// - STOP released by interrupt, then stabilization wait
// - Registers, memory and port latches held in standby
// - STOP on internal clock keeps internal oscillator
// - STOP never stops a running internal oscillator
// - Internal-clock CPU waits 17 internal periods after STOP
// - Internal halt bit works only when option allows
// - Status cleared on reset, STOP, halt/main-off writes
// - Status bits set in order at thresholds, sticky
// - Status register read-only, bit or byte readable
// - Post-STOP counting limited to selected wait
// - Post-STOP wait counted from oscillation start only
// - Select register resets 05H, codes pick wait
// - Selected wait applies only on high-speed CPU clock
`default_nettype none

package sbc_pkg;

	// Register map and reset values
	localparam logic [15:0] SETTLE_STATUS_ADDR = 16'hffa3;
	localparam logic [15:0] SETTLE_SELECT_ADDR = 16'hffa4;
	localparam logic [7:0]  SETTLE_STATUS_RST  = 8'h00;
	localparam logic [2:0]  SETTLE_SELECT_RST  = 3'h5;

	// Thresholds: status bit i sets after 2**EXP periods
	localparam int          NUM_STEPS          = 5;
	localparam int          CNT_W              = 17;
	localparam int          STEP_EXP [NUM_STEPS] = '{16, 15, 14, 13, 11};
	localparam logic [CNT_W-1:0] CNT_MAX       = 17'h10000;

	// Select codes (low three bits of the select register)
	localparam logic [2:0]  SEL_2P11           = 3'h1;
	localparam logic [2:0]  SEL_2P13           = 3'h2;
	localparam logic [2:0]  SEL_2P14           = 3'h3;
	localparam logic [2:0]  SEL_2P15           = 3'h4;
	localparam logic [2:0]  SEL_2P16           = 3'h5;

	// Status bit index of each threshold
	localparam int          BIT_2P16           = 0;
	localparam int          BIT_2P15           = 1;
	localparam int          BIT_2P14           = 2;
	localparam int          BIT_2P13           = 3;
	localparam int          BIT_2P11           = 4;

	// Internal oscillator periods held after STOP on internal clock
	localparam logic [4:0]  INT_WAIT_PERIODS   = 5'h11;

	// Standby sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_RUN  = 5'h01,
		ST_HALT = 5'h02,
		ST_STOP = 5'h04,
		ST_WHS  = 5'h08,
		ST_WINT = 5'h10
	} sbc_state_t;

	// Special function register request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        bit_acc;
		logic [2:0]  bitsel;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} sbc_sfr_req_t;

	// Clock and hold controls driven out of the block
	typedef struct packed {
		logic cpu_clk_en;
		logic hs_osc_enable;
		logic int_osc_enable;
		logic standby_hold;
	} sbc_clk_ctl_t;

endpackage : sbc_pkg

`default_nettype wire

// *** verif/sbc_standby_chk.sv ***
`default_nettype none

module sbc_standby_chk (
	// Clock and reset
	input wire logic                  clock,
	input wire logic                  resetn,
	// Requests seen by the block
	input wire logic                  halt_exec,
	input wire logic                  stop_exec,
	input wire logic                  irq_pending,
	input wire logic                  cpu_on_subsys,
	input wire logic                  main_osc_halt_bit,
	input wire logic                  internal_osc_halt_bit,
	input wire logic                  opt_int_osc_stoppable,
	input wire sbc_pkg::sbc_sfr_req_t sfr_req,
	// Block responses
	input wire logic                  sfr_rvalid,
	input wire sbc_pkg::sbc_clk_ctl_t clk_ctl,
	input wire logic                  halt_active,
	input wire logic                  stop_active
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// Release from STOP, then a CPU clock that stays off for the next 8 cycles
	sequence s_stop_release;
		stop_active && irq_pending;
	endsequence
	sequence s_cpu_held;
		!clk_ctl.cpu_clk_en [*8];
	endsequence

	AST_HALT_ENTRY: assert property (clk_ctl.cpu_clk_en && halt_exec && !stop_exec |=>
		halt_active && !clk_ctl.cpu_clk_en) else $error("halt entry wrong");
	AST_STOP_ENTRY: assert property (clk_ctl.cpu_clk_en && stop_exec && !cpu_on_subsys |=>
		stop_active && !clk_ctl.hs_osc_enable && !clk_ctl.cpu_clk_en) else $error("stop entry wrong");
	AST_HALT_RELEASE: assert property (halt_active && irq_pending |=> clk_ctl.cpu_clk_en)
		else $error("halt release late");
	AST_STOP_WAIT: assert property (s_stop_release |=> s_cpu_held)
		else $error("stop released without wait");
	AST_HALT_OSC: assert property (halt_active && $stable(main_osc_halt_bit) |->
		clk_ctl.hs_osc_enable == !main_osc_halt_bit) else $error("oscillator lost in halt");
	AST_INT_OSC: assert property ($past(resetn) && $stable(opt_int_osc_stoppable) &&
		$stable(internal_osc_halt_bit) |-> clk_ctl.int_osc_enable ==
		!(opt_int_osc_stoppable && internal_osc_halt_bit)) else $error("internal osc enable wrong");
	AST_RVALID: assert property ($past(resetn) |-> sfr_rvalid == $past(sfr_req.rd))
		else $error("read valid timing wrong");
	AST_STOP_SUBSYS: assert property (clk_ctl.cpu_clk_en && stop_exec && !halt_exec &&
		cpu_on_subsys |=> clk_ctl.cpu_clk_en && !stop_active) else $error("stop on subsystem taken");
endmodule : sbc_standby_chk

bind sbc_standby sbc_standby_chk i_chk (
	.clock(clock), .resetn(resetn), .halt_exec(halt_exec), .stop_exec(stop_exec),
	.irq_pending(irq_pending), .cpu_on_subsys(cpu_on_subsys),
	.main_osc_halt_bit(main_osc_halt_bit), .internal_osc_halt_bit(internal_osc_halt_bit),
	.opt_int_osc_stoppable(opt_int_osc_stoppable), .sfr_req(sfr_req), .sfr_rvalid(sfr_rvalid),
	.clk_ctl(clk_ctl), .halt_active(halt_active), .stop_active(stop_active)
);

`default_nettype wire

// *** verif/standby_halt_stop_control_test.sv ***
`default_nettype none

module standby_halt_stop_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clock = 1'b0, resetn = 1'b0, halt_exec = 1'b0, stop_exec = 1'b0;
	logic                  irq = 1'b0, on_int = 1'b0, on_sub = 1'b0, mhalt_wr1 = 1'b0;
	logic                  main_off_wr1 = 1'b0, ihalt = 1'b0, opt = 1'b0, mhalt_bit = 1'b0;
	logic                  hs_osc = 1'b0, int_osc = 1'b0, rvalid, halt_active, stop_active;
	logic [7:0]            rdata, q;
	sbc_pkg::sbc_sfr_req_t sfr_req = '0;
	sbc_pkg::sbc_clk_ctl_t clk_ctl;
	int                    n_fail = 0, total_checks = 0, n;

	sbc_standby i_dut (
		.clock(clock), .resetn(resetn), .halt_exec(halt_exec), .stop_exec(stop_exec),
		.irq_pending(irq), .cpu_on_internal(on_int), .cpu_on_subsys(on_sub),
		.main_osc_halt_bit(mhalt_bit), .main_osc_halt_wr1(mhalt_wr1),
		.cpu_clock_main_off_wr1(main_off_wr1), .internal_osc_halt_bit(ihalt),
		.opt_int_osc_stoppable(opt), .hs_osc_clk_in(hs_osc), .int_osc_clk_in(int_osc),
		.sfr_req(sfr_req), .sfr_rdata(rdata), .sfr_rvalid(rvalid), .clk_ctl(clk_ctl),
		.halt_active(halt_active), .stop_active(stop_active)
	);

	// Oscillators only toggle while enabled, so a halted crystal really stands still
	always #2.5 clock = ~clock;
	always #10 if (clk_ctl.hs_osc_enable === 1'b1) hs_osc = ~hs_osc;
	always #15 if (clk_ctl.int_osc_enable === 1'b1) int_osc = ~int_osc;

	task automatic final_report;
		if (n_fail == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	// One register access; answer is registered, so it is taken one edge later
	task automatic sfr(input logic w, b, input logic [2:0] s, input logic [15:0] a,
			input logic [7:0] d);
		sfr_req = '{rd: !w, wr: w, bit_acc: b, bitsel: s, addr: a, wdata: d};
		@(negedge clock);
		q = rdata;
		if (!w) check("rvalid", 32'(rvalid), 32'h1);
		// Idle one cycle so the next call never drives the request twice in one step
		sfr_req = '0;
		@(negedge clock);
	endtask : sfr

	task automatic rd_chk(input string what, input logic [15:0] a, input logic b,
			input logic [2:0] s, input logic [7:0] exp);
		sfr(1'b0, b, s, a, 8'h00);
		check(what, 32'(q), 32'(exp));
	endtask : rd_chk

	task automatic cyc(input int k);
		repeat (k) @(negedge clock);
	endtask : cyc

	// Bounded wait for the CPU clock to come back
	task automatic wait_run(input int limit);
		n = 0;
		while (clk_ctl.cpu_clk_en !== 1'b1 && n < limit) begin
			cyc(1);
			n++;
		end
		if (n == limit) begin
			n_fail++;
			final_report();
		end
	endtask : wait_run

	initial begin
		cyc(16);
		resetn = 1'b1;
		rd_chk("status rst", sbc_pkg::SETTLE_STATUS_ADDR, 0, 0, 8'h00);
		rd_chk("select rst", sbc_pkg::SETTLE_SELECT_ADDR, 0, 0, 8'h05);
		rd_chk("unmapped", 16'hffa5, 0, 0, 8'h00);
		sfr(1, 0, 0, sbc_pkg::SETTLE_STATUS_ADDR, 8'hff);
		rd_chk("status ro", sbc_pkg::SETTLE_STATUS_ADDR, 0, 0, 8'h00);
		sfr(1, 1, 3'h1, sbc_pkg::SETTLE_SELECT_ADDR, 8'hff);
		sfr(1, 0, 0, sbc_pkg::SETTLE_SELECT_ADDR, 8'h01);
		rd_chk("select", sbc_pkg::SETTLE_SELECT_ADDR, 0, 0, 8'h01);
		cyc(8400);
		rd_chk("status 2p11", sbc_pkg::SETTLE_STATUS_ADDR, 0, 0, 8'h10);
		// HALT keeps the oscillator and resumes on the next edge
		halt_exec = 1'b1;
		cyc(1);
		halt_exec = 1'b0;
		check("halt", 32'({clk_ctl.cpu_clk_en, halt_active, clk_ctl.hs_osc_enable}), 32'h3);
		cyc(5);
		irq = 1'b1;
		cyc(1);
		irq = 1'b0;
		check("halt release", 32'(clk_ctl.cpu_clk_en), 32'h1);
		// STOP on the high-speed clock waits 2^11 oscillator edges
		// Bench has no peripherals or converter running before standby
		stop_exec = 1'b1;
		cyc(1);
		stop_exec = 1'b0;
		check("stop", 32'({clk_ctl.cpu_clk_en, stop_active, clk_ctl.hs_osc_enable}), 32'h2);
		rd_chk("status stop", sbc_pkg::SETTLE_STATUS_ADDR, 0, 0, 8'h00);
		cyc(5);
		irq = 1'b1;
		wait_run(20000);
		irq = 1'b0;
		check("stop wait", 32'(n > 2048), 32'h1);
		rd_chk("status wait", sbc_pkg::SETTLE_STATUS_ADDR, 0, 0, 8'h10);
		cyc(8400);
		rd_chk("status held", sbc_pkg::SETTLE_STATUS_ADDR, 0, 0, 8'h10);
		rd_chk("status bit", sbc_pkg::SETTLE_STATUS_ADDR, 1, 3'h4, 8'h01);
		// Clear by write-one pulses, then counting restarts from zero
		main_off_wr1 = 1'b1;
		cyc(1);
		main_off_wr1 = 1'b0;
		rd_chk("clr main off", sbc_pkg::SETTLE_STATUS_ADDR, 0, 0, 8'h00);
		cyc(8400);
		rd_chk("recount", sbc_pkg::SETTLE_STATUS_ADDR, 0, 0, 8'h10);
		mhalt_wr1 = 1'b1;
		cyc(1);
		mhalt_wr1 = 1'b0;
		rd_chk("clr halt bit", sbc_pkg::SETTLE_STATUS_ADDR, 0, 0, 8'h00);
		// STOP on the internal clock keeps that oscillator and waits 17 of its periods
		on_int = 1'b1;
		stop_exec = 1'b1;
		cyc(1);
		stop_exec = 1'b0;
		check("stop int", 32'({stop_active, clk_ctl.int_osc_enable}), 32'h3);
		irq = 1'b1;
		wait_run(2000);
		irq = 1'b0;
		on_int = 1'b0;
		check("int wait", 32'(n >= 96), 32'h1);
		// STOP from the subsystem clock is not taken
		on_sub = 1'b1;
		stop_exec = 1'b1;
		cyc(1);
		stop_exec = 1'b0;
		on_sub = 1'b0;
		check("stop subsys", 32'({clk_ctl.cpu_clk_en, stop_active}), 32'h2);
		ihalt = 1'b1;
		cyc(2);
		check("int osc fixed", 32'(clk_ctl.int_osc_enable), 32'h1);
		opt = 1'b1;
		cyc(2);
		check("int osc off", 32'(clk_ctl.int_osc_enable), 32'h0);
		// Main oscillator halt bit turns the high-speed oscillator off
		mhalt_bit = 1'b1;
		cyc(2);
		check("hs osc off", 32'(clk_ctl.hs_osc_enable), 32'h0);
		mhalt_bit = 1'b0;
		cyc(2);
		check("hs osc on", 32'(clk_ctl.hs_osc_enable), 32'h1);
		final_report();
	end
endmodule : standby_halt_stop_control_test

`default_nettype wire
